// [verilog/tlic_defines.svh]
// constants of the two-level interrupt controller
// Behaviour
// - vectors 0003h pin zero, 000Bh timer zero, 0013h pin one.
// - vectors 001Bh timer one, 0023h serial, 002Bh timer two.
// - reset starts at 0000h, or the in-system programming entry when that byte is FFh.
// - edge mode sets the pin flag on a high-to-low transition.
// - level mode sets the pin flag while the pin is low; the flag then holds until software clears it.
// - pin request flags are readable in the timer control register.
// - edge mode pin flag clears when the core vectors to it.
// - timer zero and one overflow set their flags, timer zero not in mode 3.
// - timer zero and one overflow flags clear on vectoring.
// - timer two requests when enabled and overflow or external flag set.
// - timer two overflow sets on rollover, external flag on falling input edge.
// - timer two flags are never cleared on vectoring; software clears them.
// - every request flag is software writable with the same effect as hardware.
// - serial receive or transmit flag requests on one shared vector.
// - serial flags are never cleared on vectoring; software clears them.
// - on acceptance the level's in-service flag is set and the vector given.
// - return from interrupt clears the in-service flag of the active level.
// - enable register resets to zero; global enable zero inhibits every source.
// - enable register is bit-addressable, one bit changed alone.
// - equal level order: pin zero, timer zero, pin one, timer one, serial, timer two.
// - a high priority source is served before every low priority source.
// - priority bits 5 timer two down to 0 pin zero; bits 7 and 6 unused.
// - enable bits: 7 global, 5 timer two down to 0 pin zero.
// - timer two rollover in baud-rate mode sets no flag.
`ifndef TLIC_DEFINES_SVH
`define TLIC_DEFINES_SVH

`define TLIC_ADDR_TIMER_CONTROL_REG 8'h88
`define TLIC_ADDR_SCON 8'h98
`define TLIC_ADDR_IE 8'hA8
`define TLIC_ADDR_IP 8'hB8
`define TLIC_ADDR_T2CON 8'hC8

`define TLIC_IE_GLOBAL 7
`define TLIC_IE_MASK 8'hBF
`define TLIC_IE_RESET 8'h00
`define TLIC_IP_MASK 8'h3F
`define TLIC_IP_RESET 8'h00

`define TLIC_TIMER_CONTROL_REG_IT0 0
`define TLIC_TIMER_CONTROL_REG_IE0 1
`define TLIC_TIMER_CONTROL_REG_IT1 2
`define TLIC_TIMER_CONTROL_REG_IE1 3
`define TLIC_TIMER_CONTROL_REG_TF0 5
`define TLIC_TIMER_CONTROL_REG_TF1 7
`define TLIC_SCON_RI 0
`define TLIC_SCON_TI 1
`define TLIC_T2CON_TIMER_TWO_EXTERNAL_FLAG 6
`define TLIC_T2CON_TF2 7

`define TLIC_VEC_RESET 16'h0000
`define TLIC_VEC_PIN0 16'h0003
`define TLIC_VEC_T0 16'h000B
`define TLIC_VEC_PIN1 16'h0013
`define TLIC_VEC_T1 16'h001B
`define TLIC_VEC_SERIAL 16'h0023
`define TLIC_VEC_T2 16'h002B
`define TLIC_BLANK_BYTE 8'hFF
`define TLIC_ISP_ENTRY 16'hF000

`endif

// [verilog/tlic_pkg.sv]
// types of the two-level interrupt controller
package tlic_pkg;
  typedef enum logic [2:0] {
    src_pin0,
    src_t0,
    src_pin1,
    src_t1,
    src_serial,
    src_t2
  } tlic_src_type;
endpackage

// [verilog/tlic_pin_sync.sv]
// two-stage synchroniser with falling edge detect for one pin
`timescale 1ns/1ns
module tlic_pin_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // pins idle high, so a reset never looks like a falling edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign fall = last_q & ~sync_q;
endmodule

// [verilog/tlic_prio_resolve.sv]
// picks the winning pending source under two levels and in-service state
`timescale 1ns/1ns
module tlic_prio_resolve (
  input wire logic [5:0] pending,
  input wire logic [5:0] prio,
  input wire logic in_service_hi,
  input wire logic in_service_lo,
  output logic found,
  output tlic_pkg::tlic_src_type src,
  output logic level
);
  import tlic_pkg::*;
  logic [5:0] hi_pend;
  logic [5:0] cand;
  logic hi_any;

  always_comb begin
    hi_pend = pending & prio;
    hi_any = |hi_pend;
    // high level running blocks all; low level running lets only high through
    if (in_service_hi) begin
      cand = 6'h00;
    end else if (hi_any) begin
      cand = hi_pend;
    end else if (in_service_lo) begin
      cand = 6'h00;
    end else begin
      cand = pending;
    end
    found = |cand;
    level = hi_any & ~in_service_hi;
    src = src_pin0;
    // highest index first so the lowest index, first in natural order, wins
    for (int i = 5; i >= 0; i--) begin
      if (cand[i]) begin
        src = tlic_src_type'(i[2:0]);
      end
    end
  end
endmodule

// [verilog/tlic_irq_ctrl.sv]
// two-level interrupt controller: flags, enables, priority and vectoring
`timescale 1ns/1ns
`include "tlic_defines.svh"
module tlic_irq_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_bit_val,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata_q,
  input wire logic pin_irq_zero,
  input wire logic pin_irq_one,
  input wire logic timer_two_external_input,
  input wire logic t0_overflow,
  input wire logic t0_mode3,
  input wire logic t1_overflow,
  input wire logic t2_overflow,
  input wire logic t2_baud_mode,
  input wire logic rx_done,
  input wire logic tx_done,
  input wire logic irq_ack,
  input wire logic return_from_interrupt,
  input wire logic [7:0] code_byte_zero,
  output logic irq_req_q,
  output logic [15:0] irq_vector_q,
  output tlic_pkg::tlic_src_type irq_source_q,
  output logic irq_level_q,
  output logic [1:0] in_service_q,
  output logic [15:0] start_vector_q,
  output logic start_valid_q
);
  import tlic_pkg::*;

  logic [7:0] irq_enable_reg_q;
  logic [7:0] irq_priority_level_q;
  logic pin_zero_edge_sel_q;
  logic pin_one_edge_sel_q;
  logic pin_zero_req_flag_q;
  logic pin_one_req_flag_q;
  logic timer_zero_overflow_flag_q;
  logic timer_one_overflow_flag_q;
  logic timer_two_overflow_flag_q;
  logic timer_two_external_flag_q;
  logic serial_rx_flag_q;
  logic serial_tx_flag_q;

  logic [2:0] pin_raw;
  logic [2:0] pin_level;
  logic [2:0] pin_fall;
  logic wr_any;
  logic hit_timer_control_reg;
  logic hit_scon;
  logic hit_ie;
  logic hit_ip;
  logic hit_t2con;
  logic [7:0] timer_control_reg_cur;
  logic [7:0] scon_cur;
  logic [7:0] t2con_cur;
  logic [7:0] timer_control_reg_new;
  logic [7:0] scon_new;
  logic [7:0] t2con_new;
  logic [7:0] ie_new;
  logic [7:0] ip_new;
  logic ack_take;
  logic [5:0] pending;
  logic res_found;
  tlic_src_type res_src;
  logic res_level;

  // one synchroniser per asynchronous pin
  assign pin_raw = {timer_two_external_input, pin_irq_one, pin_irq_zero};
  generate
    for (genvar g = 0; g < 3; g++) begin : g_pin
      tlic_pin_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin(pin_raw[g]),
        .level(pin_level[g]),
        .fall(pin_fall[g])
      );
    end
  endgenerate

  // byte write replaces all bits, bit write changes one bit only
  function automatic logic [7:0] merge_write(
    input logic [7:0] old,
    input logic hit,
    input logic byte_wr,
    input logic bit_wr,
    input logic [7:0] data,
    input logic [2:0] sel,
    input logic val
  );
    logic [7:0] res;
    res = old;
    if (hit && byte_wr) begin
      res = data;
    end else if (hit && bit_wr) begin
      res[sel] = val;
    end
    return res;
  endfunction

  // a hardware set beats both a software clear and a vectoring clear
  function automatic logic flag_next(
    input logic cur,
    input logic hw_set,
    input logic sw_wr,
    input logic sw_val,
    input logic ack_clr
  );
    logic res;
    res = cur;
    if (hw_set) begin
      res = 1'b1;
    end else if (sw_wr) begin
      res = sw_val;
    end else if (ack_clr) begin
      res = 1'b0;
    end
    return res;
  endfunction

  // register decode and current images
  always_comb begin
    wr_any = sfr_wr | sfr_bit_wr;
    hit_timer_control_reg = (sfr_addr == `TLIC_ADDR_TIMER_CONTROL_REG);
    hit_scon = (sfr_addr == `TLIC_ADDR_SCON);
    hit_ie = (sfr_addr == `TLIC_ADDR_IE);
    hit_ip = (sfr_addr == `TLIC_ADDR_IP);
    hit_t2con = (sfr_addr == `TLIC_ADDR_T2CON);
    timer_control_reg_cur = 8'h00;
    timer_control_reg_cur[`TLIC_TIMER_CONTROL_REG_IT0] = pin_zero_edge_sel_q;
    timer_control_reg_cur[`TLIC_TIMER_CONTROL_REG_IE0] = pin_zero_req_flag_q;
    timer_control_reg_cur[`TLIC_TIMER_CONTROL_REG_IT1] = pin_one_edge_sel_q;
    timer_control_reg_cur[`TLIC_TIMER_CONTROL_REG_IE1] = pin_one_req_flag_q;
    timer_control_reg_cur[`TLIC_TIMER_CONTROL_REG_TF0] = timer_zero_overflow_flag_q;
    timer_control_reg_cur[`TLIC_TIMER_CONTROL_REG_TF1] = timer_one_overflow_flag_q;
    scon_cur = 8'h00;
    scon_cur[`TLIC_SCON_RI] = serial_rx_flag_q;
    scon_cur[`TLIC_SCON_TI] = serial_tx_flag_q;
    t2con_cur = 8'h00;
    t2con_cur[`TLIC_T2CON_TF2] = timer_two_overflow_flag_q;
    t2con_cur[`TLIC_T2CON_TIMER_TWO_EXTERNAL_FLAG] = timer_two_external_flag_q;
    timer_control_reg_new = merge_write(timer_control_reg_cur, hit_timer_control_reg, sfr_wr, sfr_bit_wr, sfr_wdata,
                           sfr_bit_sel, sfr_bit_val);
    scon_new = merge_write(scon_cur, hit_scon, sfr_wr, sfr_bit_wr, sfr_wdata,
                           sfr_bit_sel, sfr_bit_val);
    t2con_new = merge_write(t2con_cur, hit_t2con, sfr_wr, sfr_bit_wr, sfr_wdata,
                            sfr_bit_sel, sfr_bit_val);
    ie_new = merge_write(irq_enable_reg_q, hit_ie, sfr_wr, sfr_bit_wr, sfr_wdata,
                         sfr_bit_sel, sfr_bit_val);
    ip_new = merge_write(irq_priority_level_q, hit_ip, sfr_wr, sfr_bit_wr, sfr_wdata,
                         sfr_bit_sel, sfr_bit_val);
  end

  // the core vectors only to a request that is currently offered
  assign ack_take = irq_ack & irq_req_q;

  // enable and priority registers; reserved bits stay zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_enable_reg_q <= `TLIC_IE_RESET;
      irq_priority_level_q <= `TLIC_IP_RESET;
    end else begin
      irq_enable_reg_q <= ie_new & `TLIC_IE_MASK;
      irq_priority_level_q <= ip_new & `TLIC_IP_MASK;
    end
  end

  // edge selects for both pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_zero_edge_sel_q <= 1'b0;
      pin_one_edge_sel_q <= 1'b0;
    end else begin
      pin_zero_edge_sel_q <= timer_control_reg_new[`TLIC_TIMER_CONTROL_REG_IT0];
      pin_one_edge_sel_q <= timer_control_reg_new[`TLIC_TIMER_CONTROL_REG_IT1];
    end
  end

  // pin request flags: edge mode by falling edge, level mode while low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_zero_req_flag_q <= 1'b0;
      pin_one_req_flag_q <= 1'b0;
    end else begin
      pin_zero_req_flag_q <= flag_next(
        pin_zero_req_flag_q,
        pin_zero_edge_sel_q ? pin_fall[0] : ~pin_level[0],
        hit_timer_control_reg & wr_any,
        timer_control_reg_new[`TLIC_TIMER_CONTROL_REG_IE0],
        ack_take & (irq_source_q == src_pin0) & pin_zero_edge_sel_q);
      pin_one_req_flag_q <= flag_next(
        pin_one_req_flag_q,
        pin_one_edge_sel_q ? pin_fall[1] : ~pin_level[1],
        hit_timer_control_reg & wr_any,
        timer_control_reg_new[`TLIC_TIMER_CONTROL_REG_IE1],
        ack_take & (irq_source_q == src_pin1) & pin_one_edge_sel_q);
    end
  end

  // timer zero and one overflow flags, cleared on vectoring
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_zero_overflow_flag_q <= 1'b0;
      timer_one_overflow_flag_q <= 1'b0;
    end else begin
      timer_zero_overflow_flag_q <= flag_next(
        timer_zero_overflow_flag_q,
        t0_overflow & ~t0_mode3,
        hit_timer_control_reg & wr_any,
        timer_control_reg_new[`TLIC_TIMER_CONTROL_REG_TF0],
        ack_take & (irq_source_q == src_t0));
      timer_one_overflow_flag_q <= flag_next(
        timer_one_overflow_flag_q,
        t1_overflow,
        hit_timer_control_reg & wr_any,
        timer_control_reg_new[`TLIC_TIMER_CONTROL_REG_TF1],
        ack_take & (irq_source_q == src_t1));
    end
  end

  // timer two flags: never cleared by vectoring
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_two_overflow_flag_q <= 1'b0;
      timer_two_external_flag_q <= 1'b0;
    end else begin
      timer_two_overflow_flag_q <= flag_next(
        timer_two_overflow_flag_q,
        t2_overflow & ~t2_baud_mode,
        hit_t2con & wr_any,
        t2con_new[`TLIC_T2CON_TF2],
        1'b0);
      timer_two_external_flag_q <= flag_next(
        timer_two_external_flag_q,
        pin_fall[2],
        hit_t2con & wr_any,
        t2con_new[`TLIC_T2CON_TIMER_TWO_EXTERNAL_FLAG],
        1'b0);
    end
  end

  // serial flags: never cleared by vectoring
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_rx_flag_q <= 1'b0;
      serial_tx_flag_q <= 1'b0;
    end else begin
      serial_rx_flag_q <= flag_next(serial_rx_flag_q, rx_done, hit_scon & wr_any,
                                    scon_new[`TLIC_SCON_RI], 1'b0);
      serial_tx_flag_q <= flag_next(serial_tx_flag_q, tx_done, hit_scon & wr_any,
                                    scon_new[`TLIC_SCON_TI], 1'b0);
    end
  end

  // per-source requests gated by own enable and the global enable
  always_comb begin
    pending[0] = pin_zero_req_flag_q;
    pending[1] = timer_zero_overflow_flag_q;
    pending[2] = pin_one_req_flag_q;
    pending[3] = timer_one_overflow_flag_q;
    pending[4] = serial_rx_flag_q | serial_tx_flag_q;
    pending[5] = timer_two_overflow_flag_q | timer_two_external_flag_q;
    pending = pending & irq_enable_reg_q[5:0]
              & {6{irq_enable_reg_q[`TLIC_IE_GLOBAL]}};
  end

  tlic_prio_resolve u_resolve (
    .pending(pending),
    .prio(irq_priority_level_q[5:0]),
    .in_service_hi(in_service_q[1]),
    .in_service_lo(in_service_q[0]),
    .found(res_found),
    .src(res_src),
    .level(res_level)
  );

  // offered request; dropped for a cycle after acceptance so stale state is not offered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req_q <= 1'b0;
      irq_source_q <= src_pin0;
      irq_level_q <= 1'b0;
      irq_vector_q <= `TLIC_VEC_PIN0;
    end else begin
      irq_req_q <= res_found & ~ack_take;
      if (!ack_take) begin
        irq_source_q <= res_src;
        irq_level_q <= res_level;
        case (res_src)
          src_pin0: irq_vector_q <= `TLIC_VEC_PIN0;
          src_t0: irq_vector_q <= `TLIC_VEC_T0;
          src_pin1: irq_vector_q <= `TLIC_VEC_PIN1;
          src_t1: irq_vector_q <= `TLIC_VEC_T1;
          src_serial: irq_vector_q <= `TLIC_VEC_SERIAL;
          src_t2: irq_vector_q <= `TLIC_VEC_T2;
          default: irq_vector_q <= `TLIC_VEC_PIN0;
        endcase
      end
    end
  end

  // in-service flags: bit 1 high level, bit 0 low level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_service_q <= 2'b00;
    end else if (ack_take) begin
      in_service_q[irq_level_q] <= 1'b1;
    end else if (return_from_interrupt) begin
      // the innermost routine is the high one whenever both are active
      if (in_service_q[1]) begin
        in_service_q[1] <= 1'b0;
      end else begin
        in_service_q[0] <= 1'b0;
      end
    end
  end

  // start address chosen once after reset release from the byte at 0000h
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_valid_q <= 1'b0;
      start_vector_q <= `TLIC_VEC_RESET;
    end else if (!start_valid_q) begin
      start_valid_q <= 1'b1;
      if (code_byte_zero == `TLIC_BLANK_BYTE) begin
        start_vector_q <= `TLIC_ISP_ENTRY;
      end else begin
        start_vector_q <= `TLIC_VEC_RESET;
      end
    end
  end

  // register read data, held until the next read; unmapped reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      if (hit_timer_control_reg) begin
        sfr_rdata_q <= timer_control_reg_cur;
      end else if (hit_scon) begin
        sfr_rdata_q <= scon_cur;
      end else if (hit_ie) begin
        sfr_rdata_q <= irq_enable_reg_q;
      end else if (hit_ip) begin
        sfr_rdata_q <= irq_priority_level_q;
      end else if (hit_t2con) begin
        sfr_rdata_q <= t2con_cur;
      end else begin
        sfr_rdata_q <= 8'h00;
      end
    end
  end
endmodule

// [testbench/tlic_irq_ctrl_props.sv]
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ns
`include "tlic_defines.svh"
module tlic_irq_ctrl_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic irq_ack,
  input wire logic return_from_interrupt,
  input wire logic [7:0] code_byte_zero,
  input wire logic irq_req_q,
  input wire logic [15:0] irq_vector_q,
  input wire tlic_pkg::tlic_src_type irq_source_q,
  input wire logic irq_level_q,
  input wire logic [1:0] in_service_q,
  input wire logic [15:0] start_vector_q,
  input wire logic start_valid_q
);
  import tlic_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence accept_s;
    irq_req_q && irq_ack;
  endsequence
  // an accept in the same cycle outranks the return
  sequence ret_s;
    return_from_interrupt && !(irq_req_q && irq_ack);
  endsequence
  ack_drops_req_a: assert property (accept_s |=> !irq_req_q)
    else $error("request still offered after accept");
  hi_enter_a: assert property (accept_s ##0 irq_level_q |=> in_service_q[1])
    else $error("high in-service not set");
  lo_enter_a: assert property (accept_s ##0 !irq_level_q |=> in_service_q[0])
    else $error("low in-service not set");
  vector_map_a: assert property (irq_req_q |->
    irq_vector_q == (16'h0003 + {10'h000, irq_source_q, 3'h0}))
    else $error("vector does not match source");
  hi_blocks_a: assert property (in_service_q[1] |-> !irq_req_q)
    else $error("request offered during high routine");
  lo_blocks_a: assert property (in_service_q[0] && irq_req_q |-> irq_level_q)
    else $error("low request offered during low routine");
  hi_return_a: assert property (ret_s ##0 in_service_q[1] |=>
    !in_service_q[1] && in_service_q[0] == $past(in_service_q[0]))
    else $error("return did not clear high level only");
  lo_return_a: assert property (ret_s ##0 in_service_q == 2'b01 |=> in_service_q == 2'b00)
    else $error("return did not clear low level");
  start_addr_a: assert property ($rose(start_valid_q) |-> start_vector_q ==
    ((code_byte_zero == `TLIC_BLANK_BYTE) ? `TLIC_ISP_ENTRY : `TLIC_VEC_RESET))
    else $error("wrong start vector");
endmodule
bind tlic_irq_ctrl tlic_irq_ctrl_props u_tlic_irq_ctrl_props (
  .clk(clk), .rst_b(rst_b), .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
  .code_byte_zero(code_byte_zero), .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q),
  .irq_source_q(irq_source_q), .irq_level_q(irq_level_q), .in_service_q(in_service_q),
  .start_vector_q(start_vector_q), .start_valid_q(start_valid_q));

// [testbench/tlic_core_model.sv]
// behavioural core: accepts offered requests, returns on command
`timescale 1ns/1ns
module tlic_core_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic irq_req_q,
  input wire logic [15:0] irq_vector_q,
  input wire logic irq_level_q,
  input wire logic [1:0] in_service_q,
  input wire logic slow,
  input wire logic release_isr,
  output logic irq_ack,
  output logic return_from_interrupt,
  output logic [15:0] taken_vec,
  output logic taken_lvl,
  output logic [7:0] taken_n
);
  logic [1:0] wait_q;
  // slow mode lets the offer stand four cycles before the accept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      irq_ack <= 1'b0;
      if (irq_req_q && !irq_ack) begin
        wait_q <= wait_q + 2'h1;
        if (!slow || wait_q == 2'h3) begin
          irq_ack <= 1'b1;
          wait_q <= 2'h0;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      taken_vec <= 16'h0000;
      taken_lvl <= 1'b0;
      taken_n <= 8'h00;
    end else if (irq_req_q && irq_ack) begin
      taken_vec <= irq_vector_q;
      taken_lvl <= irq_level_q;
      taken_n <= taken_n + 8'h01;
    end
  end
  // one return per release pulse, none while idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      return_from_interrupt <= 1'b0;
    else
      return_from_interrupt <= release_isr && |in_service_q && !return_from_interrupt;
  end
endmodule

// [testbench/tlic_irq_ctrl_bench.sv]
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ns
module tlic_irq_ctrl_bench;
  import tlic_pkg::*;
  // event bit, vector, level, flag register, its value after vectoring
  typedef struct {int k; logic [15:0] vec; logic lvl; logic [7:0] fa; logic [7:0] fv;} tlic_row_type;
  logic clk, rst_b, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, t0_mode3, t2_baud_mode;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, ev, code_byte_zero, seen_n, taken_n;
  logic [2:0] sfr_bit_sel;
  logic irq_req_q, irq_level_q, start_valid_q, irq_ack, return_from_interrupt;
  logic slow, release_isr, taken_lvl;
  logic [15:0] irq_vector_q, start_vector_q, taken_vec;
  logic [1:0] in_service_q;
  tlic_src_type irq_source_q;
  int num_errors, num_checks, cycles;
  tlic_row_type rows [8] = '{
    '{0, 16'h0003, 1'b0, 8'h88, 8'h05}, '{1, 16'h000B, 1'b1, 8'h88, 8'h05},
    '{2, 16'h0013, 1'b0, 8'h88, 8'h05}, '{3, 16'h001B, 1'b1, 8'h88, 8'h05},
    '{4, 16'h0023, 1'b0, 8'h98, 8'h01}, '{5, 16'h0023, 1'b1, 8'h98, 8'h02},
    '{6, 16'h002B, 1'b0, 8'hC8, 8'h80}, '{7, 16'h002B, 1'b1, 8'hC8, 8'h40}};
  // pins are active low, so event bits drive them inverted
  tlic_irq_ctrl u_tlic_irq_ctrl (
    .clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
    .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q), .pin_irq_zero(~ev[0]), .pin_irq_one(~ev[2]),
    .timer_two_external_input(~ev[7]), .t0_overflow(ev[1]), .t0_mode3(t0_mode3),
    .t1_overflow(ev[3]), .t2_overflow(ev[6]), .t2_baud_mode(t2_baud_mode), .rx_done(ev[4]),
    .tx_done(ev[5]), .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
    .code_byte_zero(code_byte_zero), .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q),
    .irq_source_q(irq_source_q), .irq_level_q(irq_level_q), .in_service_q(in_service_q),
    .start_vector_q(start_vector_q), .start_valid_q(start_valid_q));
  tlic_core_model u_tlic_core_model (
    .clk(clk), .rst_b(rst_b), .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q),
    .irq_level_q(irq_level_q), .in_service_q(in_service_q), .slow(slow),
    .release_isr(release_isr), .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
    .taken_vec(taken_vec), .taken_lvl(taken_lvl), .taken_n(taken_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_bit_sel <= s;
    sfr_bit_val <= v;
    sfr_bit_wr <= 1'b1;
    @(posedge clk);
    sfr_bit_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    chk("read data", {8'h00, sfr_rdata_q}, {8'h00, e});
  endtask
  // timer and serial bits pulse one cycle; pin bits stay low for 13 cycles
  task automatic fire(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= m & 8'h85;
    repeat (12) @(posedge clk);
    ev <= 8'h00;
  endtask
  task automatic await(input logic [15:0] v, input logic l);
    for (int i = 0; i < 40 && taken_n == seen_n; i++)
      @(posedge clk);
    #1;
    // a stale vector from an earlier accept must not pass for a missing one
    chk("accept count", {8'h00, taken_n}, {8'h00, seen_n + 8'h01});
    seen_n = taken_n;
    chk("taken vector", taken_vec, v);
    chk("taken level", {15'h0000, taken_lvl}, {15'h0000, l});
  endtask
  task automatic ret();
    @(posedge clk);
    release_isr <= 1'b1;
    @(posedge clk);
    release_isr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    rst_b <= 1'b0;
    {sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, t0_mode3, t2_baud_mode} <= 6'h00;
    {sfr_addr, sfr_wdata, ev, code_byte_zero} <= 32'h0000_0000;
    sfr_bit_sel <= 3'h0;
    {slow, release_isr} <= 2'h0;
    seen_n = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wr(8'h88, 8'h05);
    chk("start vector", start_vector_q, 16'h0000);
    foreach (rows[i]) begin
      slow <= i[0];
      wr(8'hB8, rows[i].lvl ? 8'h3F : 8'h00);
      wr(8'hA8, 8'hBF);
      fire(8'h01 << rows[i].k);
      await(rows[i].vec, rows[i].lvl);
      rd(rows[i].fa, rows[i].fv);
      wr(rows[i].fa, rows[i].fa == 8'h88 ? 8'h05 : 8'h00);
      ret();
    end
    wr(8'hA8, 8'h3F);
    wr(8'hB8, 8'h08);
    fire(8'h1A);
    #1;
    chk("request while globally off", {15'h0000, irq_req_q}, 16'h0000);
    bwr(8'hA8, 3'h7, 1'b1);
    await(16'h001B, 1'b1);
    ret();
    await(16'h000B, 1'b0);
    fire(8'h08);
    await(16'h001B, 1'b1);
    ret();
    ret();
    await(16'h0023, 1'b0);
    rd(8'h88, 8'h05);
    wr(8'h98, 8'h00);
    ret();
    wr(8'h88, 8'h00);
    wr(8'hB8, 8'h00);
    wr(8'hA8, 8'h84);
    @(posedge clk);
    ev <= 8'h04;
    await(16'h0013, 1'b0);
    rd(8'h88, 8'h08);
    @(posedge clk);
    ev <= 8'h00;
    repeat (4) @(posedge clk);
    wr(8'h88, 8'h00);
    rd(8'h88, 8'h00);
    ret();
    t0_mode3 <= 1'b1;
    t2_baud_mode <= 1'b1;
    fire(8'h42);
    rd(8'h88, 8'h00);
    rd(8'hC8, 8'h00);
    @(posedge clk);
    t0_mode3 <= 1'b0;
    t2_baud_mode <= 1'b0;
    wr(8'hA8, 8'h90);
    wr(8'h98, 8'h02);
    await(16'h0023, 1'b0);
    wr(8'h98, 8'h00);
    ret();
    wr(8'hA8, 8'hFF);
    rd(8'hA8, 8'hBF);
    wr(8'hB8, 8'hFF);
    rd(8'hB8, 8'h3F);
    bwr(8'hA8, 3'h7, 1'b0);
    rd(8'hA8, 8'h3F);
    @(posedge clk);
    rst_b <= 1'b0;
    code_byte_zero <= 8'hFF;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("start vector", start_vector_q, 16'hF000);
    rd(8'hA8, 8'h00);
    rd(8'hB8, 8'h00);
    rd(8'h00, 8'h00);
    close_out();
  end
endmodule
